/* File: rtl/citd_pkg.sv */
// package: opcode classes, timing figures and states for the cycle decoder
package citd_pkg;

    // timing figures in core clock cycles, and instruction lengths in bytes
    localparam logic [3:0] CYC_ONE       = 4'h1;
    localparam logic [3:0] CYC_TWO       = 4'h2;
    localparam logic [3:0] CYC_THREE     = 4'h3;
    localparam logic [3:0] CYC_FOUR      = 4'h4;
    localparam logic [3:0] CYC_EIGHT     = 4'h8;
    localparam logic [3:0] CYC_CODE_MIN  = 4'h4;
    localparam logic [3:0] CYC_CODE_MAX  = 4'h7;
    localparam logic [1:0] LEN_ONE       = 2'h1;
    localparam logic [1:0] LEN_TWO       = 2'h2;
    localparam logic [1:0] LEN_THREE     = 2'h3;

    // stack pointer value after reset
    localparam logic [7:0] SP_RESET      = 8'h07;

    // opcode values with special handling
    localparam logic [7:0] OP_INC_PTR    = 8'hA3;
    localparam logic [7:0] OP_MUL        = 8'hA4;
    localparam logic [7:0] OP_DIV        = 8'h84;
    localparam logic [7:0] OP_PUSH       = 8'hC0;
    localparam logic [7:0] OP_LOAD_PTR   = 8'h90;
    localparam logic [7:0] OP_CODE_PTR   = 8'h93;
    localparam logic [7:0] OP_CODE_PC    = 8'h83;
    localparam logic [7:0] OP_XD_RD_RI0  = 8'hE2;
    localparam logic [7:0] OP_XD_RD_RI1  = 8'hE3;
    localparam logic [7:0] OP_XD_RD_PTR  = 8'hE0;
    localparam logic [7:0] OP_XD_WR_RI0  = 8'hF2;
    localparam logic [7:0] OP_XD_WR_RI1  = 8'hF3;
    localparam logic [7:0] OP_XD_WR_PTR  = 8'hF0;

    // decoder sequencing
    typedef enum logic [1:0] {CITD_IDLE, CITD_BUSY} citd_state_e;

endpackage

/* File: rtl/citd_if.sv */
// interface: timing lookup request and answer between the decoder and its table
`timescale 1ns/1ps
interface citd_lut_if;
    logic [7:0] opcode;
    logic       lookup;
    logic [1:0] length;
    logic [3:0] cycles;
    logic       known;
    logic       xd_move;
    logic       xd_write;
    logic       code_read;
    logic       push;

    modport dec (output opcode, output lookup,
                 input length, input cycles, input known,
                 input xd_move, input xd_write, input code_read, input push);
    modport lut (input opcode, input lookup,
                 output length, output cycles, output known,
                 output xd_move, output xd_write, output code_read, output push);
endinterface

/* File: rtl/citd_lut.sv */
// registered opcode to byte-length and cycle-count table
`timescale 1ns/1ps
module citd_lut
    import citd_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // lookup
    citd_lut_if.lut  lk
);

    typedef struct packed {
        logic [1:0] length;
        logic [3:0] cycles;
        logic       known;
        logic       xd_move;
        logic       xd_write;
        logic       code_read;
        logic       push;
    } citd_lut_s;

    citd_lut_s st_reg;
    citd_lut_s st_next;
    logic [2:0] hi;
    logic [3:0] lo;

    // decode the opcode into length and cycles; answer one cycle after lookup
    always_comb
    begin
        st_next = st_reg;
        hi = lk.opcode[7:5];
        lo = lk.opcode[3:0];
        if (lk.lookup)
        begin
            st_next = '0;
            st_next.known = 1'b1;
            // column pattern shared by arithmetic, logic and accumulator moves
            if (lo >= 4'h8)
            begin
                st_next.length = LEN_ONE;          // register source
                st_next.cycles = CYC_ONE;
            end
            else if (lo >= 4'h6)
            begin
                st_next.length = LEN_ONE;          // indirect ram source
                st_next.cycles = CYC_TWO;
            end
            else if (lo == 4'h5)
            begin
                st_next.length = LEN_TWO;          // direct byte
                st_next.cycles = CYC_TWO;
            end
            else if (lo == 4'h4)
            begin
                st_next.length = LEN_TWO;          // immediate
                st_next.cycles = CYC_TWO;
            end
            else
                st_next.known = 1'b0;
            unique case (lk.opcode[7:4])
                4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6: ;
                4'h0, 4'h1:
                begin
                    if (lo == 4'h4)
                    begin
                        st_next.length = LEN_ONE;  // accumulator form
                        st_next.cycles = CYC_ONE;
                    end
                end
                4'hE:
                begin
                    if (lo == 4'h4)
                    begin
                        st_next.length = LEN_ONE;  // clear accumulator
                        st_next.cycles = CYC_ONE;
                    end
                end
                4'hF:
                begin
                    if (lo == 4'h4)
                    begin
                        st_next.length = LEN_ONE;
                        st_next.cycles = CYC_ONE;  // complement accumulator
                    end
                    else if (lo == 4'h5)
                    begin
                        st_next.length = LEN_TWO;
                        st_next.cycles = CYC_TWO;
                    end
                    else if (lo >= 4'h6 && lo <= 4'h7)
                        st_next.cycles = CYC_TWO;
                    else if (lo >= 4'h8)
                        st_next.cycles = CYC_ONE;
                end
                4'h7, 4'hA, 4'h8:
                begin
                    if (lo >= 4'h8)
                    begin
                        st_next.length = LEN_TWO;
                        st_next.cycles = CYC_TWO;
                    end
                    else if (lo >= 4'h6)
                    begin
                        st_next.length = LEN_TWO;
                        st_next.cycles = CYC_TWO;
                    end
                    else if (lo == 4'h5 && lk.opcode[7:4] != 4'hA)  // direct or immediate into direct
                    begin
                        st_next.length = LEN_THREE;
                        st_next.cycles = CYC_THREE;
                    end
                    else if (lo == 4'h4 && lk.opcode[7:4] == 4'h7)
                    begin
                        st_next.length = LEN_TWO;
                        st_next.cycles = CYC_TWO;
                    end
                    else
                        st_next.known = 1'b0;
                end
                default:                                   // others
                begin
                    st_next.known = 1'b0;
                    if (lo == 4'h4 || lk.opcode[7:4] == 4'hC || lk.opcode[7:4] == 4'hD)
                    begin
                        st_next.known  = (lo == 4'h4);
                        st_next.length = LEN_ONE;
                        st_next.cycles = CYC_ONE;
                    end
                end
            endcase
            // direct-destination logic ops in column 2, then the three-byte immediate forms in column 3 of rows 4..6
            if ((hi == 3'h2 || hi == 3'h3 || lk.opcode[7:4] == 4'h6) && lo == 4'h2)
            begin
                st_next.known  = 1'b1;
                st_next.length = LEN_TWO;
                st_next.cycles = CYC_TWO;
            end
            if ((lk.opcode[7:4] >= 4'h4 && lk.opcode[7:4] <= 4'h6) && lo == 4'h3)
            begin
                st_next.known  = 1'b1;
                st_next.length = LEN_THREE;
                st_next.cycles = CYC_THREE;
            end
            // rotates sit in column 3 of rows 0..3; column 4 is immediate and keeps 2/2 in rows 2..7 and 9 only
            if (lk.opcode[7:6] == 2'h0 && lo == 4'h3)
            begin
                st_next.known  = 1'b1;
                st_next.length = LEN_ONE;
                st_next.cycles = CYC_ONE;
            end
            // single opcodes
            unique case (lk.opcode)
                OP_INC_PTR:  begin st_next.known = 1'b1; st_next.length = LEN_ONE;
                             st_next.cycles = CYC_ONE; end
                OP_MUL:      begin st_next.known = 1'b1; st_next.length = LEN_ONE;
                             st_next.cycles = CYC_FOUR; end
                OP_DIV:      begin st_next.known = 1'b1; st_next.length = LEN_ONE;
                             st_next.cycles = CYC_EIGHT; end
                8'hD4:       begin st_next.known = 1'b1; st_next.length = LEN_ONE;
                             st_next.cycles = CYC_ONE; end
                OP_LOAD_PTR: begin st_next.known = 1'b1; st_next.length = LEN_THREE;
                             st_next.cycles = CYC_THREE; end
                OP_PUSH:     begin st_next.known = 1'b1; st_next.length = LEN_TWO;
                             st_next.cycles = CYC_TWO; st_next.push = 1'b1; end
                OP_CODE_PTR, OP_CODE_PC:
                             begin st_next.known = 1'b1; st_next.length = LEN_ONE;
                             st_next.cycles = CYC_CODE_MIN; st_next.code_read = 1'b1; end
                OP_XD_RD_RI0, OP_XD_RD_RI1, OP_XD_RD_PTR:
                             begin st_next.known = 1'b1; st_next.length = LEN_ONE;
                             st_next.cycles = CYC_THREE; st_next.xd_move = 1'b1; end
                OP_XD_WR_RI0, OP_XD_WR_RI1, OP_XD_WR_PTR:
                             begin st_next.known = 1'b1; st_next.length = LEN_ONE;
                             st_next.cycles = CYC_THREE; st_next.xd_move = 1'b1;
                             st_next.xd_write = 1'b1; end
                default: ;
            endcase
        end
        if (!RST_N)
            st_next = '0;
    end

    // registered answer
    always_ff @(posedge SYS_CLK)
        st_reg <= st_next;

    assign lk.length    = st_reg.length;
    assign lk.cycles    = st_reg.cycles;
    assign lk.known     = st_reg.known;
    assign lk.xd_move   = st_reg.xd_move;
    assign lk.xd_write  = st_reg.xd_write;
    assign lk.code_read = st_reg.code_read;
    assign lk.push      = st_reg.push;

endmodule

/* File: rtl/citd_top.sv */
// instruction length and cycle decoder that holds the core pipeline
`timescale 1ns/1ps
module citd_top
    import citd_pkg::*;
(
    // clock and reset
    input  wire logic       SYS_CLK,
    input  wire logic       RST_N,
    // instruction issue from fetch
    input  wire logic       ISSUE,
    input  wire logic [7:0] OPCODE,
    input  wire logic       PREFETCH_ENABLE,
    input  wire logic [1:0] FLASH_READ_TIMING,
    input  wire logic       CODE_ALIGN_ODD,
    input  wire logic       FLASH_TARGET,
    input  wire logic       FLASH_ERASE,
    // answers to the pipeline
    output logic            READY,
    output logic            HOLD,
    output logic            DONE,
    output logic [1:0]      LENGTH,
    output logic [3:0]      CYCLES,
    output logic            UNKNOWN_OP,
    output logic            TIMING_VALID,
    // memory strobes and stack pointer
    output logic            FLASH_WRITE,
    output logic            FLASH_ERASE_STB,
    output logic            XDATA_WRITE,
    output logic            STACK_WRITE,
    output logic [7:0]      STACK_POINTER
);

    typedef struct packed {
        citd_state_e state;
        logic [3:0]  left;
        logic        hold;
        logic        done;
        logic        ready;
        logic [1:0]  length;
        logic [3:0]  cycles;
        logic        unknown;
        logic        tvalid;
        logic        pf_en;
        logic        fl_wr;
        logic        fl_er;
        logic        xd_wr;
        logic        stk_wr;
        logic [7:0]  sp;
        logic        ftgt;
        logic        fers;
        logic [3:0]  code_cyc;
    } citd_top_s;

    citd_top_s   st_reg;
    citd_top_s   st_next;
    citd_lut_if  lk ();

    // table lookup is registered, so answers appear one cycle after issue
    citd_lut u_lut (
        .SYS_CLK (SYS_CLK),
        .RST_N   (RST_N),
        .lk      (lk)
    );

    assign lk.opcode = OPCODE;
    assign lk.lookup = ISSUE && st_reg.ready;

    // code read time: base plus alignment and flash wait setting, capped
    function automatic logic [3:0] code_time(input logic odd, input logic [1:0] frt);
        logic [3:0] t;
        t = CYC_CODE_MIN + {3'h0, odd} + {2'h0, frt};
        if (t > CYC_CODE_MAX)
            t = CYC_CODE_MAX;
        return t;
    endfunction

    // sequencing: idle takes an issue, busy counts down the table figure, or the code read time for code reads
    always_comb
    begin
        st_next        = st_reg;
        st_next.done   = 1'b0;
        st_next.fl_wr  = 1'b0;
        st_next.fl_er  = 1'b0;
        st_next.xd_wr  = 1'b0;
        st_next.stk_wr = 1'b0;
        unique case (st_reg.state)
            CITD_IDLE:
            begin
                if (ISSUE && st_reg.ready)
                begin
                    st_next.state    = CITD_BUSY;
                    st_next.ready    = 1'b0;
                    st_next.hold     = 1'b1;
                    st_next.left     = 4'h0;
                    st_next.pf_en    = PREFETCH_ENABLE;
                    st_next.ftgt     = FLASH_TARGET;
                    st_next.fers     = FLASH_ERASE;
                    st_next.code_cyc = code_time(CODE_ALIGN_ODD, FLASH_READ_TIMING);
                end
            end
            CITD_BUSY:
            begin
                if (st_reg.left == 4'h0)
                begin
                    // table answer arrives now; this cycle counts as the first
                    st_next.length  = lk.length;
                    st_next.unknown = !lk.known;
                    st_next.tvalid  = st_reg.pf_en;
                    st_next.cycles  = lk.code_read ? st_reg.code_cyc : lk.cycles;
                    st_next.left    = (lk.code_read ? st_reg.code_cyc : lk.cycles)
                                      - 4'h1;
                    if (lk.push)
                    begin
                        st_next.sp     = st_reg.sp + 8'h01;
                        st_next.stk_wr = 1'b1;
                    end
                    if (lk.xd_write)
                    begin
                        st_next.fl_wr = st_reg.ftgt && !st_reg.fers;
                        st_next.fl_er = st_reg.ftgt && st_reg.fers;
                        st_next.xd_wr = !st_reg.ftgt;
                    end
                    // an opcode with no figure releases after one held cycle, never wraps
                    if (lk.cycles <= CYC_ONE && !lk.code_read)
                    begin
                        st_next.state = CITD_IDLE;
                        st_next.hold  = 1'b0;
                        st_next.done  = 1'b1;
                        st_next.ready = 1'b1;
                    end
                end
                else
                begin
                    st_next.left = st_reg.left - 4'h1;
                    if (st_reg.left == 4'h1)
                    begin
                        st_next.state = CITD_IDLE;
                        st_next.hold  = 1'b0;
                        st_next.done  = 1'b1;
                        st_next.ready = 1'b1;
                    end
                end
            end
        endcase
        if (!RST_N)
        begin
            st_next       = '0;
            st_next.state = CITD_IDLE;
            st_next.ready = 1'b1;
            st_next.sp    = SP_RESET;
        end
    end

    // single state register
    always_ff @(posedge SYS_CLK)
        st_reg <= st_next;

    // outputs straight from the state flops
    assign READY           = st_reg.ready;
    assign HOLD            = st_reg.hold;
    assign DONE            = st_reg.done;
    assign LENGTH          = st_reg.length;
    assign CYCLES          = st_reg.cycles;
    assign UNKNOWN_OP      = st_reg.unknown;
    assign TIMING_VALID    = st_reg.tvalid;
    assign FLASH_WRITE     = st_reg.fl_wr;
    assign FLASH_ERASE_STB = st_reg.fl_er;
    assign XDATA_WRITE     = st_reg.xd_wr;
    assign STACK_WRITE     = st_reg.stk_wr;
    assign STACK_POINTER   = st_reg.sp;

    // checks
    sequence s_mul_issue;
        ISSUE && READY && OPCODE == OP_MUL;
    endsequence
    sequence s_div_issue;
        ISSUE && READY && OPCODE == OP_DIV;
    endsequence

    mul_four_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_mul_issue |=> HOLD [*4] ##1 (DONE && CYCLES == 4'h4))
        else $error("multiply not four cycles");
    div_eight_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_div_issue |=> HOLD [*8] ##1 (DONE && CYCLES == 4'h8))
        else $error("divide not eight cycles");
    inc_ptr_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (ISSUE && READY && OPCODE == OP_INC_PTR) |=> HOLD ##1 (DONE && LENGTH == 2'h1))
        else $error("pointer increment timing wrong");
    load_ptr_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (ISSUE && READY && OPCODE == OP_LOAD_PTR) |=> HOLD [*3] ##1 (DONE && LENGTH == 2'h3))
        else $error("pointer load timing wrong");
    xd_move_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (ISSUE && READY && OPCODE == OP_XD_RD_PTR) |=> HOLD [*3] ##1 DONE)
        else $error("external move not three cycles");
    push_sp_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        STACK_WRITE |-> STACK_POINTER == $past(STACK_POINTER) + 8'h01)
        else $error("push without stack pointer increment");
    code_read_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (ISSUE && READY && OPCODE == OP_CODE_PTR) |=> HOLD ##[4:7] DONE)
        else $error("code read outside four to seven cycles");
    flash_wr_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (FLASH_WRITE || FLASH_ERASE_STB) |-> !XDATA_WRITE && HOLD)
        else $error("flash strobe mixed with data write");
    add_reg_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (ISSUE && READY && OPCODE == 8'h28) |=> HOLD ##1 (DONE && CYCLES == 4'h1))
        else $error("register add not one cycle");
    push_two_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (ISSUE && READY && OPCODE == OP_PUSH) |=> HOLD [*2] ##1 (DONE && LENGTH == 2'h2))
        else $error("push not two cycles");
    done_ready_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        DONE |-> READY && !HOLD)
        else $error("done without release");

endmodule

/* File: verif/citd_fetch_model.sv */
// fetch and memory side model: hands over opcodes, times them, notes strobes
`timescale 1ns/1ps
module citd_fetch_model (
    // core answers
    input wire logic       clk,
    input wire logic       ready,
    input wire logic       hold,
    // flash write, flash erase, xdata write, stack write
    input wire logic [3:0] stb,
    input wire logic [7:0] sp
);
    logic [3:0] seen;
    logic [7:0] sp_seen;
    // memories catch each strobe; the stack byte goes where the pointer already points
    always @(negedge clk)
    begin
        seen = seen | stb;
        if (stb[0] === 1'b1)
            sp_seen = sp;
    end
    // the offer stands until a rising edge sees ready high
    task automatic take();
        logic r;
        seen = 4'h0;
        for (int w = 0; w < 40; w++)
        begin
            r = ready;
            @(posedge clk);
            #1;
            if (r === 1'b1)
                break;
        end
    endtask
    // held cycles after the taking edge; bounded so a stuck hold cannot hang
    task automatic wait_done(output int span);
        span = 0;
        @(negedge clk);
        while (hold === 1'b1 && span < 20)
        begin
            span++;
            @(negedge clk);
        end
    endtask
endmodule

/* File: verif/tb.sv */
// self-checking bench for the instruction length and cycle decoder
`timescale 1ns/1ps
module tb;
    import citd_pkg::*;
    logic       sys_clk = 1'b0, rst_n = 1'b0, issue = 1'b0, prefetch_enable = 1'b1;
    logic       code_align_odd = 1'b0, flash_target = 1'b0, flash_erase = 1'b0;
    logic       ready, hold, done, unknown_op, timing_valid;
    logic [7:0] opcode = 8'h00;
    logic [7:0] stack_pointer;
    logic [1:0] flash_read_timing = 2'h0;
    logic [1:0] length;
    logic [3:0] cycles;
    logic [3:0] stb;
    int         miscompares = 0;
    int         n_compared = 0;
    // 50 MHz core clock
    always #10 sys_clk = ~sys_clk;
    // decoder and its fetch side
    citd_top citd_top_i (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .ISSUE(issue), .OPCODE(opcode),
        .PREFETCH_ENABLE(prefetch_enable), .FLASH_READ_TIMING(flash_read_timing),
        .CODE_ALIGN_ODD(code_align_odd), .FLASH_TARGET(flash_target),
        .FLASH_ERASE(flash_erase), .READY(ready), .HOLD(hold), .DONE(done),
        .LENGTH(length), .CYCLES(cycles), .UNKNOWN_OP(unknown_op),
        .TIMING_VALID(timing_valid), .FLASH_WRITE(stb[3]), .FLASH_ERASE_STB(stb[2]),
        .XDATA_WRITE(stb[1]), .STACK_WRITE(stb[0]), .STACK_POINTER(stack_pointer)
    );
    citd_fetch_model citd_fetch_model_i (
        .clk(sys_clk), .ready(ready), .hold(hold), .stb(stb), .sp(stack_pointer)
    );
    // compare one result and count it
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // offer an opcode after an edge, unless one still stands; keep leaves the offer up
    task automatic run(input logic [7:0] op, input logic [3:0] len, input logic [3:0] cyc,
                       input logic [3:0] xs, input logic keep);
        int span;
        if (issue !== 1'b1)
        begin
            @(posedge sys_clk);
            #1;
            issue = 1'b1;
            opcode = op;
        end
        citd_fetch_model_i.take();
        issue = keep;
        citd_fetch_model_i.wait_done(span);
        chk(8'(span), 8'(cyc));
        chk(8'({done, ready, unknown_op, timing_valid}), 8'({3'h6, prefetch_enable}));
        chk(8'({length, cycles}), 8'({len[1:0], cyc}));
        chk(8'(citd_fetch_model_i.seen), 8'(xs));
    endtask
    // back-to-back pushes: second taken on the done cycle, pointer bumped before each write
    task automatic t_push();
        chk(stack_pointer, SP_RESET);
        run(OP_PUSH, LEN_TWO, CYC_TWO, 4'h1, 1'b1);
        chk(citd_fetch_model_i.sp_seen, 8'h08);
        run(OP_PUSH, LEN_TWO, CYC_TWO, 4'h1, 1'b0);
        chk(citd_fetch_model_i.sp_seen, 8'h09);
        $display("push test done");
    endtask
    // fixed-timing opcodes as opcode, length, cycles
    task automatic t_table();
        string       s;
        logic [15:0] e;
        s = {"281138119811252224223522342295229422261237129612",
             "041108110522061214111F1115221712A311A4148418",
             "D411E411F4112311331103111311C411",
             "581155225422561248114522442247126B11652264226612",
             "522253334222433362226333E811E5227422E612",
             "F811A8227822F5228822862285337533F612A62276229033E013E213"};
        for (int i = 0; i + 3 < s.len(); i += 4)
        begin
            e = 16'(s.substr(i, i + 3).atohex());
            run(e[15:8], e[7:4], e[3:0], 4'h0, 1'b0);
        end
        $display("table test done");
    endtask
    // external writes go to xdata, flash write or flash erase; reads strobe nothing
    task automatic t_xdata();
        logic [7:0] op [3] = '{OP_XD_WR_PTR, OP_XD_WR_RI0, OP_XD_WR_RI1};
        logic [3:0] xs [3] = '{4'h2, 4'h8, 4'h4};
        for (int k = 0; k < 3; k++)
        begin
            @(posedge sys_clk);
            #1;
            flash_target = (k > 0);
            flash_erase = (k > 1);
            run(op[k], LEN_ONE, CYC_THREE, xs[k], 1'b0);
            run(OP_XD_RD_RI1, LEN_ONE, CYC_THREE, 4'h0, 1'b0);
        end
        $display("xdata test done");
    endtask
    // code reads over both alignments and all flash timings; the sum saturates at seven
    task automatic t_code();
        logic [3:0] cyc;
        for (int a = 0; a < 2; a++)
            for (int t = 0; t < 4; t++)
            begin
                @(posedge sys_clk);
                #1;
                code_align_odd = a[0];
                flash_read_timing = t[1:0];
                cyc = (a + t > 3) ? CYC_CODE_MAX : CYC_CODE_MIN + 4'(a + t);
                run(t[0] ? OP_CODE_PC : OP_CODE_PTR, LEN_ONE, cyc, 4'h0, 1'b0);
            end
        $display("code read test done");
    endtask
    // an issue with prefetch off is flagged as outside the covered timing
    task automatic t_pref();
        @(posedge sys_clk);
        #1;
        prefetch_enable = 1'b0;
        run(OP_DIV, LEN_ONE, CYC_EIGHT, 4'h0, 1'b0);
        @(posedge sys_clk);
        #1;
        prefetch_enable = 1'b1;
        $display("prefetch test done");
    endtask
    // counts, verdict and end of run
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ten cycles of reset, then the scenarios
    initial
    begin
        repeat (10) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        t_push();
        t_table();
        t_xdata();
        t_code();
        t_pref();
        report_and_stop();
    end
    // watchdog: the scenarios need well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        report_and_stop();
    end
endmodule
